/* File: src/pec_pkg.sv */
// constants, field layouts and carrier types of the event counter block
// assumes one 10 MHz pclk domain; event sources share that clock
`default_nettype none
package pec_pkg;
  localparam logic [7:0] ADDR_SEL0 = 8'h00;
  localparam logic [7:0] ADDR_SEL1 = 8'h04;
  localparam logic [7:0] ADDR_CTR0 = 8'h08;
  localparam logic [7:0] ADDR_CTR1 = 8'h0c;
  localparam logic [7:0] ADDR_RATIO = 8'h10;
  localparam logic [7:0] ADDR_STAT = 8'h14;
  localparam logic [7:0] ADDR_MASK = 8'h18;
  localparam int SEL_CODE_LSB = 0;
  localparam int SEL_UMASK_LSB = 8;
  localparam int SEL_PC_BIT = 19;
  localparam int SEL_EN_BIT = 22;
  localparam logic [7:0] EV_HIT_DRV = 8'h7a;
  localparam logic [7:0] EV_SNOOP_HIT_MODIFIED_PIN_DRV = 8'h7b;
  localparam logic [7:0] EV_SNOOP_STALL = 8'h7e;
  localparam logic [7:0] EV_FP_RETIRED = 8'hc1;
  localparam logic [7:0] EV_FP_EXECUTED = 8'h10;
  localparam logic [7:0] EV_FP_MICROCODE_ASSIST_EVENT = 8'h11;
  localparam logic [7:0] EV_MULTIPLY = 8'h12;
  localparam logic [7:0] UMASK_SELF = 8'h00;
  localparam logic [2:0] RATIO_2TO1 = 3'h2;
  localparam logic [2:0] RATIO_3TO1 = 3'h3;
  localparam logic [2:0] RATIO_RST = 3'h2;
  localparam logic [31:0] SEL_RST = 32'h0000_0000;
  localparam logic [31:0] CTR_RST = 32'h0000_0000;
  localparam logic [31:0] CTR_MAX = 32'hffff_ffff;
  localparam logic [1:0] MASK_RST = 2'h0;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } pec_apb_t;

  typedef struct packed {
    logic bus_tick;
    logic hit_drv;
    logic snoop_hit_modified_pin_drv;
    logic hit_stall_drv;
    logic snoop_hit_modified_pin_stall_drv;
    logic snoop_stall;
    logic fpr_comp;
    logic fpr_trap;
    logic fpr_assist;
    logic fpr_ldst;
    logic fpr_handler;
    logic fpr_subop;
    logic fpx_op_start;
    logic fpx_transc_add;
    logic fpa_assist;
    logic fpa_spec_assist;
    logic mul_int;
    logic mul_fp;
  } pec_evt_t;

  typedef struct packed {
    logic [1:0][31:0] sel;
    logic [1:0][31:0] ctr;
    logic [2:0] ratio;
    logic [1:0] stat;
    logic [1:0] mask;
    logic [1:0] mon;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pec_state_t;
endpackage
`default_nettype wire

/* File: src/pec_counter.sv */
// two event counters with apb registers, monitor pins and overflow interrupt
// assumes event inputs are driven by logic on pclk, one cycle per pulse
//
// Summary of operation
// - code 7AH, mask 00H: count bus cycles this device drives snoop hit
// - code 7BH: count bus cycles this device drives snoop hit-modified
// - both snoop drive events also count cycles driven during snoop stalls
// - snoop events, ratio 2:1 or 3:1, pin bit set: pin pulses one clock
// - pin bit clear: pin level inverts on each counter overflow
// - other clock ratios give no pin indication; counting stays correct
// - code 7EH, mask 00H: count clock cycles of bus snoop stall
// - code C1H counts retired computational fp operations, counter 0 only
// - retired fp event skips operations that trap or need an assist
// - retired fp event counts assist handler ops and internal sub-ops
// - retired fp event skips fp loads and stores
// - code 10H counts executed computational fp ops, counter 0 only
// - executed fp event counts once per operation, not per cycle
// - adds inside transcendental flows count like standalone adds
// - code 11H counts microcode-handled fp exceptions, counter 1 only
// - assist event includes speculative occurrences
// - code 12H counts integer and fp multiplies, counter 1 only
//
// Implementation choices: the register addresses and register access over APB.
`default_nettype none
module pec_counter
  import pec_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire pec_apb_t apb_i,
  input wire pec_evt_t evt_i,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [1:0] monitor_pin,
  output logic irq
);

  pec_state_t st_q;
  pec_state_t st_d;
  logic [1:0] inc_c;
  logic [1:0] ovf_c;
  logic [1:0] snoop_c;
  logic ratio_ok_c;
  logic wr_c;
  logic rd_c;
  logic setup_c;

  // one increment decision for a counter from its selected event
  function automatic logic pec_inc(input logic [31:0] sel, input int idx,
                                   input pec_evt_t ev);
    logic [7:0] code;
    logic [7:0] umask;
    logic r;
    code = sel[SEL_CODE_LSB +: 8];
    umask = sel[SEL_UMASK_LSB +: 8];
    r = 1'b0;
    case (code)
      EV_HIT_DRV: begin
        r = (umask == UMASK_SELF) && ev.bus_tick &&
            (ev.hit_drv || ev.hit_stall_drv);
      end
      EV_SNOOP_HIT_MODIFIED_PIN_DRV: begin
        r = ev.bus_tick && (ev.snoop_hit_modified_pin_drv || ev.snoop_hit_modified_pin_stall_drv);
      end
      EV_SNOOP_STALL: begin
        r = (umask == UMASK_SELF) && ev.snoop_stall;
      end
      EV_FP_RETIRED: begin
        r = (idx == 0) &&
            ((ev.fpr_comp && !ev.fpr_trap && !ev.fpr_assist && !ev.fpr_ldst) ||
             ev.fpr_handler || ev.fpr_subop);
      end
      EV_FP_EXECUTED: begin
        r = (idx == 0) && (ev.fpx_op_start || ev.fpx_transc_add);
      end
      EV_FP_MICROCODE_ASSIST_EVENT: begin
        r = (idx == 1) && (ev.fpa_assist || ev.fpa_spec_assist);
      end
      EV_MULTIPLY: begin
        r = (idx == 1) && (ev.mul_int || ev.mul_fp);
      end
      default: begin
        r = 1'b0;
      end
    endcase
    return r && sel[SEL_EN_BIT];
  endfunction

  function automatic logic pec_is_snoop(input logic [31:0] sel);
    return (sel[SEL_CODE_LSB +: 8] == EV_HIT_DRV) ||
           (sel[SEL_CODE_LSB +: 8] == EV_SNOOP_HIT_MODIFIED_PIN_DRV);
  endfunction

  always_comb begin
    st_d = st_q;
    setup_c = apb_i.psel && !st_q.pready;
    wr_c = apb_i.psel && apb_i.penable && st_q.pready && apb_i.pwrite;
    rd_c = apb_i.psel && apb_i.penable && st_q.pready && !apb_i.pwrite;
    ratio_ok_c = (st_q.ratio == RATIO_2TO1) || (st_q.ratio == RATIO_3TO1);
    st_d.pready = 1'b0;
    st_d.pslverr = 1'b0;
    // answer one cycle after an unanswered request; read data captured then
    if (setup_c) begin
      st_d.pready = 1'b1;
      st_d.prdata = 32'h0000_0000;
      case (apb_i.paddr)
        ADDR_SEL0: begin
          st_d.prdata = st_q.sel[0];
        end
        ADDR_SEL1: begin
          st_d.prdata = st_q.sel[1];
        end
        ADDR_CTR0: begin
          st_d.prdata = st_q.ctr[0];
        end
        ADDR_CTR1: begin
          st_d.prdata = st_q.ctr[1];
        end
        ADDR_RATIO: begin
          st_d.prdata = {29'h0, st_q.ratio};
        end
        ADDR_STAT: begin
          st_d.prdata = {30'h0, st_q.stat};
        end
        ADDR_MASK: begin
          st_d.prdata = {30'h0, st_q.mask};
        end
        default: begin
          st_d.pslverr = 1'b1;
        end
      endcase
    end
    // a status read clears only the bits it returned; new overflows below win
    if (rd_c && apb_i.paddr == ADDR_STAT) begin
      st_d.stat = st_q.stat & ~st_q.prdata[1:0];
    end
    for (int i = 0; i < 2; i++) begin
      inc_c[i] = pec_inc(st_q.sel[i], i, evt_i);
      ovf_c[i] = inc_c[i] && (st_q.ctr[i] == CTR_MAX);
      snoop_c[i] = pec_is_snoop(st_q.sel[i]);
      if (inc_c[i]) begin
        st_d.ctr[i] = st_q.ctr[i] + 32'h0000_0001;
      end
      if (st_q.sel[i][SEL_PC_BIT]) begin
        st_d.mon[i] = 1'b0;
      end
      if (ovf_c[i] && snoop_c[i] && ratio_ok_c) begin
        st_d.mon[i] = st_q.sel[i][SEL_PC_BIT] ? 1'b1 : !st_q.mon[i];
      end
      if (ovf_c[i]) begin
        st_d.stat[i] = 1'b1;
      end
    end
    if (wr_c) begin
      case (apb_i.paddr)
        ADDR_SEL0: begin
          st_d.sel[0] = apb_i.pwdata;
        end
        ADDR_SEL1: begin
          st_d.sel[1] = apb_i.pwdata;
        end
        ADDR_CTR0: begin
          st_d.ctr[0] = apb_i.pwdata;
        end
        ADDR_CTR1: begin
          st_d.ctr[1] = apb_i.pwdata;
        end
        ADDR_RATIO: begin
          st_d.ratio = apb_i.pwdata[2:0];
        end
        ADDR_MASK: begin
          st_d.mask = apb_i.pwdata[1:0];
        end
        default: begin
          st_d.ratio = st_d.ratio;
        end
      endcase
    end
    st_d.irq = |(st_d.stat & st_d.mask);
  end

  // ce low freezes all state: keep ce high across an apb transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q.sel <= {SEL_RST, SEL_RST};
      st_q.ctr <= {CTR_RST, CTR_RST};
      st_q.ratio <= RATIO_RST;
      st_q.stat <= 2'h0;
      st_q.mask <= MASK_RST;
      st_q.mon <= 2'h0;
      st_q.irq <= 1'b0;
      st_q.pready <= 1'b0;
      st_q.pslverr <= 1'b0;
      st_q.prdata <= 32'h0000_0000;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign monitor_pin = st_q.mon;
  assign irq = st_q.irq;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_hit_count_inc: assert property (
    ce && !wr_c && st_q.sel[0][7:0] == EV_HIT_DRV &&
    st_q.sel[0][15:8] == UMASK_SELF && st_q.sel[0][SEL_EN_BIT] &&
    evt_i.bus_tick && evt_i.hit_drv
    |=> st_q.ctr[0] == $past(st_q.ctr[0]) + 32'h0000_0001)
    else $error("hit drive cycle not counted");

  a_stall_drv_count: assert property (
    ce && !wr_c && st_q.sel[1][7:0] == EV_SNOOP_HIT_MODIFIED_PIN_DRV &&
    st_q.sel[1][SEL_EN_BIT] && evt_i.bus_tick && evt_i.snoop_hit_modified_pin_stall_drv
    |=> st_q.ctr[1] == $past(st_q.ctr[1]) + 32'h0000_0001)
    else $error("stall driven cycle not counted");

  a_pin_pulse_one: assert property (
    ce && st_q.mon[0] && st_q.sel[0][SEL_PC_BIT] && !ovf_c[0]
    |=> !st_q.mon[0])
    else $error("monitor pulse longer than one clock");

  a_pin_toggle_ovf: assert property (
    ce && ovf_c[0] && snoop_c[0] && ratio_ok_c && !st_q.sel[0][SEL_PC_BIT]
    |=> st_q.mon[0] != $past(st_q.mon[0]))
    else $error("monitor pin did not toggle");

  a_pin_bad_ratio: assert property (
    ce && !ratio_ok_c && !st_q.sel[1][SEL_PC_BIT]
    |=> st_q.mon[1] == $past(st_q.mon[1]))
    else $error("monitor pin moved at bad ratio");

  a_fp_trap_skip: assert property (
    ce && !wr_c && st_q.sel[0][7:0] == EV_FP_RETIRED && evt_i.fpr_trap &&
    !evt_i.fpr_handler && !evt_i.fpr_subop
    |=> $stable(st_q.ctr[0]))
    else $error("trapping fp op counted");

  a_fp_ldst_skip: assert property (
    ce && !wr_c && st_q.sel[0][7:0] == EV_FP_RETIRED && evt_i.fpr_ldst &&
    !evt_i.fpr_handler && !evt_i.fpr_subop
    |=> $stable(st_q.ctr[0]))
    else $error("fp load or store counted");

  a_restrict_other: assert property (
    ce && !wr_c && (st_q.sel[1][7:0] == EV_FP_RETIRED ||
    st_q.sel[1][7:0] == EV_FP_EXECUTED)
    |=> $stable(st_q.ctr[1]))
    else $error("restricted event counted on counter 1");

  a_mul_count: assert property (
    ce && !wr_c && st_q.sel[1][7:0] == EV_MULTIPLY &&
    st_q.sel[1][SEL_EN_BIT] && evt_i.mul_fp
    |=> st_q.ctr[1] == $past(st_q.ctr[1]) + 32'h0000_0001)
    else $error("multiply not counted");

  a_ovf_sticky: assert property (
    ce && !wr_c && ovf_c[1]
    |=> st_q.stat[1] && st_q.ctr[1] == 32'h0000_0000)
    else $error("overflow not flagged");

  a_snoop_hit_modified_pin_count_inc: assert property (
    ce && !wr_c && st_q.sel[1][7:0] == EV_SNOOP_HIT_MODIFIED_PIN_DRV &&
    st_q.sel[1][SEL_EN_BIT] && evt_i.bus_tick && evt_i.snoop_hit_modified_pin_drv
    |=> st_q.ctr[1] == $past(st_q.ctr[1]) + 32'h0000_0001)
    else $error("hit-modified drive cycle not counted");

  a_hit_umask_skip: assert property (
    ce && !wr_c && st_q.sel[0][7:0] == EV_HIT_DRV &&
    st_q.sel[0][15:8] != UMASK_SELF
    |=> $stable(st_q.ctr[0]))
    else $error("hit drive counted with foreign unit mask");

  a_stall_count: assert property (
    ce && !wr_c && st_q.sel[0][7:0] == EV_SNOOP_STALL &&
    st_q.sel[0][15:8] == UMASK_SELF && st_q.sel[0][SEL_EN_BIT] && evt_i.snoop_stall
    |=> st_q.ctr[0] == $past(st_q.ctr[0]) + 32'h0000_0001)
    else $error("snoop stall cycle not counted");

  a_fp_ret_count: assert property (
    ce && !wr_c && st_q.sel[0][7:0] == EV_FP_RETIRED && st_q.sel[0][SEL_EN_BIT] &&
    evt_i.fpr_comp && !evt_i.fpr_trap && !evt_i.fpr_assist && !evt_i.fpr_ldst
    |=> st_q.ctr[0] == $past(st_q.ctr[0]) + 32'h0000_0001)
    else $error("retired fp op not counted");

  a_fp_microcode_assist_event_skip: assert property (
    ce && !wr_c && st_q.sel[0][7:0] == EV_FP_RETIRED && evt_i.fpr_assist &&
    !evt_i.fpr_handler && !evt_i.fpr_subop
    |=> $stable(st_q.ctr[0]))
    else $error("assisted fp op counted");

  a_fp_handler_count: assert property (
    ce && !wr_c && st_q.sel[0][7:0] == EV_FP_RETIRED && st_q.sel[0][SEL_EN_BIT] &&
    (evt_i.fpr_handler || evt_i.fpr_subop)
    |=> st_q.ctr[0] == $past(st_q.ctr[0]) + 32'h0000_0001)
    else $error("handler or sub-op not counted");

  a_fp_exe_count: assert property (
    ce && !wr_c && st_q.sel[0][7:0] == EV_FP_EXECUTED && st_q.sel[0][SEL_EN_BIT] &&
    evt_i.fpx_op_start
    |=> st_q.ctr[0] == $past(st_q.ctr[0]) + 32'h0000_0001)
    else $error("executed fp op not counted");

  a_fp_exe_once: assert property (
    ce && !wr_c && st_q.sel[0][7:0] == EV_FP_EXECUTED &&
    !evt_i.fpx_op_start && !evt_i.fpx_transc_add
    |=> $stable(st_q.ctr[0]))
    else $error("executed fp event counted without an op start");

  a_fp_transc_add: assert property (
    ce && !wr_c && st_q.sel[0][7:0] == EV_FP_EXECUTED && st_q.sel[0][SEL_EN_BIT] &&
    evt_i.fpx_transc_add
    |=> st_q.ctr[0] == $past(st_q.ctr[0]) + 32'h0000_0001)
    else $error("add inside transcendental flow not counted");

  a_assist_count: assert property (
    ce && !wr_c && st_q.sel[1][7:0] == EV_FP_MICROCODE_ASSIST_EVENT &&
    st_q.sel[1][SEL_EN_BIT] && evt_i.fpa_assist
    |=> st_q.ctr[1] == $past(st_q.ctr[1]) + 32'h0000_0001)
    else $error("microcode fp_microcode_assist_event not counted");

  a_spec_assist_count: assert property (
    ce && !wr_c && st_q.sel[1][7:0] == EV_FP_MICROCODE_ASSIST_EVENT &&
    st_q.sel[1][SEL_EN_BIT] && evt_i.fpa_spec_assist
    |=> st_q.ctr[1] == $past(st_q.ctr[1]) + 32'h0000_0001)
    else $error("speculative fp_microcode_assist_event not counted");

  a_restrict_ctr0: assert property (
    ce && !wr_c && (st_q.sel[0][7:0] == EV_FP_MICROCODE_ASSIST_EVENT ||
    st_q.sel[0][7:0] == EV_MULTIPLY)
    |=> $stable(st_q.ctr[0]))
    else $error("restricted event counted on counter 0");

  a_pin_bad_ratio0: assert property (
    ce && ovf_c[0] && !ratio_ok_c && !st_q.sel[0][SEL_PC_BIT]
    |=> st_q.mon[0] == $past(st_q.mon[0]))
    else $error("monitor pin toggled at bad ratio");

  a_pulse_bad_ratio: assert property (
    ce && !ratio_ok_c && st_q.sel[0][SEL_PC_BIT]
    |=> !st_q.mon[0])
    else $error("monitor pin pulsed at bad ratio");

  a_ce_freeze: assert property (
    !ce |=> $stable(st_q))
    else $error("state moved while clock enable low");

  a_stat_read_clr: assert property (
    ce && rd_c && apb_i.paddr == ADDR_STAT && st_q.prdata[0] && !ovf_c[0]
    |=> !st_q.stat[0])
    else $error("status bit not cleared by read");

  a_ctr_write: assert property (
    ce && wr_c && apb_i.paddr == ADDR_CTR0
    |=> st_q.ctr[0] == $past(apb_i.pwdata))
    else $error("counter write lost");

  c_ovf_wrap: cover property (ce && ovf_c[0] ##1 st_q.stat[0]);
  c_pin_pulse: cover property ($rose(st_q.mon[0]) ##1 $fell(st_q.mon[0]));
  c_pin_toggle: cover property ($fell(st_q.mon[1]));
  c_irq_up: cover property ($rose(st_q.irq));
  c_freeze: cover property (!ce ##1 ce);

endmodule
`default_nettype wire

/* File: tb/pec_evt_src.sv */
// event source model: replays the bench's requests one pclk cycle later as event qualifiers
// assumes requests change right after a rising pclk edge
`default_nettype none
module pec_evt_src
  import pec_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire pec_evt_t req,
  output pec_evt_t evt_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // registered like a pipeline stage would present it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_o <= '0;
    end else begin
      evt_o <= req;
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench: apb register access, event counting and overflow pins
// assumes pec_counter and the event source model pec_evt_src
`default_nettype none
module tb
  import pec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam pec_evt_t HIT = '{bus_tick: 1'b1, hit_drv: 1'b1, default: 1'b0};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce_q = 1'b1;
  pec_apb_t apb_q = '0;
  pec_evt_t req = '0;
  pec_evt_t evt;
  logic [31:0] prdata;
  logic pready, pslverr, irq, err;
  logic [1:0] monitor_pin;
  int bad_count = 0;
  int num_checks = 0;
  int hi_cnt = 0;

  always #50 pclk = ~pclk;
  always @(posedge pclk) if (monitor_pin[0] === 1'b1) hi_cnt <= hi_cnt + 1;

  pec_evt_src src (.pclk(pclk), .presetn(presetn), .req(req), .evt_o(evt));
  pec_counter dut (.pclk(pclk), .presetn(presetn), .ce(ce_q), .apb_i(apb_q), .evt_i(evt),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .monitor_pin(monitor_pin),
    .irq(irq));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
    apb_q <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    apb_q.penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    apb_q <= '0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, a, '0, r);
    chk(r, exp);
  endtask

  task automatic ev(input pec_evt_t e, input int n);
    req <= e;
    repeat (n) @(posedge pclk);
    req <= '0;
    repeat (3) @(posedge pclk);
  endtask

  task automatic t_reset();
    logic [31:0] r;
    chk({29'h0, irq, monitor_pin}, 32'h0);
    rd(ADDR_SEL0, SEL_RST);
    rd(ADDR_SEL1, SEL_RST);
    rd(ADDR_CTR0, CTR_RST);
    rd(ADDR_CTR1, CTR_RST);
    rd(ADDR_STAT, 32'h0);
    rd(ADDR_RATIO, {29'h0, RATIO_RST});
    rd(ADDR_MASK, 32'h0);
    xfer(1'b0, 8'h1c, '0, r);
    chk({r[31:1], err}, 32'h1);
    $display("reset test done");
  endtask

  task automatic t_snoop();
    wr(ADDR_SEL0, 32'h0040_007a);
    wr(ADDR_SEL1, 32'h0040_007b);
    ev('{bus_tick: 1'b1, hit_drv: 1'b1, snoop_hit_modified_pin_drv: 1'b1, default: 1'b0}, 3);
    ev('{hit_drv: 1'b1, snoop_hit_modified_pin_drv: 1'b1, default: 1'b0}, 2);
    ev('{bus_tick: 1'b1, hit_stall_drv: 1'b1, snoop_hit_modified_pin_stall_drv: 1'b1, default: 1'b0}, 2);
    rd(ADDR_CTR0, 32'h5);
    rd(ADDR_CTR1, 32'h5);
    wr(ADDR_SEL0, 32'h0040_007e);
    ev('{snoop_stall: 1'b1, default: 1'b0}, 4);
    rd(ADDR_CTR0, 32'h9);
    $display("snoop test done");
  endtask

  task automatic t_fp();
    wr(ADDR_SEL0, 32'h0040_00c1);
    wr(ADDR_SEL1, 32'h0040_00c1);
    ev('{fpr_comp: 1'b1, default: 1'b0}, 2);
    ev('{fpr_comp: 1'b1, fpr_trap: 1'b1, default: 1'b0}, 1);
    ev('{fpr_comp: 1'b1, fpr_assist: 1'b1, default: 1'b0}, 1);
    ev('{fpr_comp: 1'b1, fpr_ldst: 1'b1, default: 1'b0}, 1);
    ev('{fpr_handler: 1'b1, fpr_subop: 1'b1, default: 1'b0}, 1);
    ev('{fpr_subop: 1'b1, default: 1'b0}, 1);
    rd(ADDR_CTR0, 32'hd);
    rd(ADDR_CTR1, 32'h5);
    wr(ADDR_SEL0, 32'h0040_0010);
    wr(ADDR_SEL1, 32'h0040_0011);
    ev('{fpx_op_start: 1'b1, fpx_transc_add: 1'b1, default: 1'b0}, 1);
    ev('{fpx_transc_add: 1'b1, default: 1'b0}, 1);
    ev('{fpa_spec_assist: 1'b1, default: 1'b0}, 2);
    ev('{fpa_assist: 1'b1, default: 1'b0}, 1);
    rd(ADDR_CTR0, 32'hf);
    rd(ADDR_CTR1, 32'h8);
    wr(ADDR_SEL0, 32'h0040_0012);
    wr(ADDR_SEL1, 32'h0040_0012);
    ev('{mul_int: 1'b1, default: 1'b0}, 1);
    ev('{mul_fp: 1'b1, default: 1'b0}, 1);
    rd(ADDR_CTR0, 32'hf);
    rd(ADDR_CTR1, 32'ha);
    $display("fp test done");
  endtask

  task automatic t_ovf();
    wr(ADDR_MASK, 32'h1);
    wr(ADDR_SEL0, 32'h0040_007a);
    wr(ADDR_CTR0, CTR_MAX);
    ev(HIT, 1);
    chk({30'h0, monitor_pin}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rd(ADDR_CTR0, 32'h0);
    rd(ADDR_STAT, 32'h1);
    rd(ADDR_STAT, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(ADDR_CTR0, CTR_MAX);
    ev(HIT, 1);
    chk({30'h0, monitor_pin}, 32'h0);
    $display("toggle test done");
  endtask

  task automatic t_pulse();
    int h0;
    wr(ADDR_RATIO, 32'h3);
    wr(ADDR_SEL0, 32'h0048_007a);
    wr(ADDR_CTR0, CTR_MAX);
    h0 = hi_cnt;
    ev(HIT, 1);
    repeat (4) @(posedge pclk);
    chk(hi_cnt - h0, 32'h1);
    chk({30'h0, monitor_pin}, 32'h0);
    $display("pulse test done");
  endtask

  task automatic t_ratio();
    wr(ADDR_RATIO, 32'h5);
    wr(ADDR_SEL0, 32'h0040_007a);
    wr(ADDR_CTR0, CTR_MAX);
    ev(HIT, 1);
    chk({30'h0, monitor_pin}, 32'h0);
    rd(ADDR_CTR0, 32'h0);
    $display("ratio test done");
  endtask

  task automatic t_freeze();
    ce_q <= 1'b0;
    ev(HIT, 2);
    ce_q <= 1'b1;
    rd(ADDR_CTR0, 32'h0);
    ev(HIT, 1);
    rd(ADDR_CTR0, 32'h1);
    $display("freeze test done");
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_snoop();
    t_fp();
    t_ovf();
    t_pulse();
    t_ratio();
    t_freeze();
    tally_and_finish();
  end

  // the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge pclk);
    bad_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
